// ==== design/ebsc_top.sv ====
`timescale 1ns/1ps
`include "ebsc_map.svh"
module ebsc_top (
  input wire logic REF_CLK_I, // system clock
  input wire logic RST_I, // async reset, active high
  input wire logic REQ_VALID_I, // core starts an access
  input wire ebsc_pkg::ebsc_req_s REQ_I, // access descriptor
  output logic REQ_DONE_O, // access finished, one cycle
  input wire logic WRITE_STROBE_CONFIG_FIELD_I, // 0 full, 1 low-byte mode
  input wire logic READY_EN_I, // ready function enable
  input wire logic [`EBSC_WAIT_W-1:0] WAIT_CNT_I, // programmed wait states
  input wire logic READY_I, // external ready, high = wait
  input wire logic [7:0] CAN_SEL_I, // per line: 1 = CAN use
  input wire logic [7:0] CAN_TX_I, // CAN transmit data per line
  output logic [7:0] CAN_RX_O, // CAN receive data per line
  input wire logic [7:0] SEG_PORT_I, // segment_address_port pins in
  output logic [7:0] SEG_PORT_O, // segment_address_port pins out
  output logic [7:0] SEG_PORT_OE_O, // pin drive enables
  output logic RD_N_O, // read strobe, active low
  output logic WR_N_O // write_strobe_low_byte, active low
);
  // ==========================================
  // input synchronisers
  // ready and port pins are asynchronous, two stages each
  logic rdy_m_r, rdy_s_r;
  logic [7:0] pin_m_r, pin_s_r;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdy_m_r <= `EBSC_SYNC_RST;
      rdy_s_r <= `EBSC_SYNC_RST;
      pin_m_r <= `EBSC_PIN_RST;
      pin_s_r <= `EBSC_PIN_RST;
    end else begin
      rdy_m_r <= READY_I;
      rdy_s_r <= rdy_m_r;
      pin_m_r <= SEG_PORT_I;
      pin_s_r <= pin_m_r;
    end
  end
  assign CAN_RX_O = pin_s_r & CAN_SEL_I;

  // ==========================================
  // access sequencer
  ebsc_pkg::ebsc_state_e st_r, st_nxt;
  ebsc_pkg::ebsc_req_s req_r;
  logic [`EBSC_WAIT_W-1:0] cnt_r, cnt_nxt;
  wire start = (st_r == ebsc_pkg::EBSC_IDLE) && REQ_VALID_I;
  wire cnt_zero = (cnt_r == `EBSC_WAIT_RST);
  // synced ready lags the pin by two cycles
  wire rdy_hold = READY_EN_I && rdy_s_r;
  wire active = (st_r != ebsc_pkg::EBSC_IDLE);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ebsc_pkg::EBSC_IDLE: begin
        if (REQ_VALID_I) begin
          st_nxt = ebsc_pkg::EBSC_WAIT;
          cnt_nxt = WAIT_CNT_I;
        end
      end
      ebsc_pkg::EBSC_WAIT: begin
        if (!cnt_zero) cnt_nxt = cnt_r - 1'h1;
        else st_nxt = ebsc_pkg::EBSC_RDY;
      end
      ebsc_pkg::EBSC_RDY: begin
        if (!rdy_hold) st_nxt = ebsc_pkg::EBSC_IDLE;
      end
      default: st_nxt = ebsc_pkg::EBSC_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= ebsc_pkg::EBSC_IDLE;
      cnt_r <= `EBSC_WAIT_RST;
      req_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      if (start) req_r <= REQ_I;
    end
  end
  assign REQ_DONE_O = (st_r == ebsc_pkg::EBSC_RDY) && !rdy_hold;

  // ==========================================
  // strobes
  wire rd_act = active && (req_r.fetch || req_r.rd);
  wire rd_take = REQ_I.fetch || REQ_I.rd;
  wire busy_nxt = (st_nxt != ebsc_pkg::EBSC_IDLE);
  // fetches never drive the write strobe
  wire wr_any = active && req_r.wr && !req_r.fetch;
  wire wr_low = wr_any && (req_r.bus8 || req_r.low_byte);
  wire wr_lowb_mode = (WRITE_STROBE_CONFIG_FIELD_I == `EBSC_WR_STROBE_LOWB);
  wire wr_act = wr_lowb_mode ? wr_low : wr_any;
  logic rd_n_r, wr_n_r;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_n_r <= `EBSC_STROBE_RST;
      wr_n_r <= `EBSC_STROBE_RST;
    end else begin
      rd_n_r <= !(busy_nxt && (start ? rd_take : rd_act));
      // write strobe trails the take edge by one cycle
      wr_n_r <= `EBSC_STROBE_RST;
      if (busy_nxt && !start) wr_n_r <= !wr_act;
    end
  end
  assign RD_N_O = rd_n_r;
  assign WR_N_O = wr_n_r;

  // ==========================================
  // segment port: bit 0 = segment_addr_lsb, bit 7 = segment_addr_msb
  logic [7:0] seg_r;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) seg_r <= `EBSC_SEG_RST;
    else if (start) seg_r <= REQ_I.seg;
  end
  // lines with CAN selected bypass the segment latch
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign SEG_PORT_O[g] = CAN_SEL_I[g] ? CAN_TX_I[g] : seg_r[g];
    end
  endgenerate
  assign SEG_PORT_OE_O = 8'hFF;

  // ==========================================
  // checks
  property p_rd;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (rd_act && busy_nxt) |=> !RD_N_O;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe missing");
  property p_wr_full;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (wr_any && WRITE_STROBE_CONFIG_FIELD_I == `EBSC_WR_STROBE_FULL && busy_nxt) |=> !WR_N_O;
  endproperty
  a_wr_full: assert property (p_wr_full) else $error("full write strobe missing");
  property p_wr_low;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (wr_any && wr_lowb_mode && !req_r.bus8 && !req_r.low_byte) |=> WR_N_O;
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("high byte write strobed");
  property p_wr_cfg;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (wr_any && (req_r.bus8 || req_r.low_byte) && st_nxt != ebsc_pkg::EBSC_IDLE)
      |=> !WR_N_O;
  endproperty
  a_wr_cfg: assert property (p_wr_cfg) else $error("low write strobe missing");
  property p_rdy;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (st_r == ebsc_pkg::EBSC_RDY && rdy_hold) |-> !REQ_DONE_O;
  endproperty
  a_rdy: assert property (p_rdy) else $error("done while ready held");
  property p_seg;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (start && CAN_SEL_I == 8'h00) |=> (SEG_PORT_O == $past(REQ_I.seg)) || CAN_SEL_I != 8'h00;
  endproperty
  a_seg: assert property (p_seg) else $error("segment port order wrong");
  property p_can;
    @(posedge REF_CLK_I) disable iff (RST_I)
      ((SEG_PORT_O ^ CAN_TX_I) & CAN_SEL_I) == 8'h00;
  endproperty
  a_can: assert property (p_can) else $error("CAN line not routed");
  property p_nordy;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (st_r == ebsc_pkg::EBSC_RDY && !READY_EN_I) |-> REQ_DONE_O;
  endproperty
  a_nordy: assert property (p_nordy) else $error("ready not ignored");
  property p_idle;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !busy_nxt |=> RD_N_O && WR_N_O;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe outside access");
  property p_fetch_wr;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (active && req_r.fetch) |=> WR_N_O;
  endproperty
  a_fetch_wr: assert property (p_fetch_wr) else $error("write strobe on fetch");
  property p_wait_load;
    @(posedge REF_CLK_I) disable iff (RST_I)
      start |=> cnt_r == $past(WAIT_CNT_I);
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("wait count not loaded");
  property p_wait_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (st_r == ebsc_pkg::EBSC_WAIT && !cnt_zero) |=> st_r == ebsc_pkg::EBSC_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait states cut short");
  property p_rdy_stay;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (st_r == ebsc_pkg::EBSC_RDY && rdy_hold) |=> st_r == ebsc_pkg::EBSC_RDY;
  endproperty
  a_rdy_stay: assert property (p_rdy_stay) else $error("access ended while ready high");
  property p_done_pulse;
    @(posedge REF_CLK_I) disable iff (RST_I)
      REQ_DONE_O |=> !REQ_DONE_O;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_can_rx;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (CAN_RX_O & ~CAN_SEL_I) == 8'h00;
  endproperty
  a_can_rx: assert property (p_can_rx) else $error("CAN receive on segment line");
  property p_seg_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (!start && CAN_SEL_I == 8'h00) |=> CAN_SEL_I != 8'h00 || $stable(SEG_PORT_O);
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("segment address moved");

  // ==========================================
  // cover points
  c_read: cover property (@(posedge REF_CLK_I) start && REQ_I.rd);
  c_write: cover property (@(posedge REF_CLK_I) start && REQ_I.wr);
  c_stretch: cover property (@(posedge REF_CLK_I) st_r == ebsc_pkg::EBSC_RDY && rdy_hold);
  c_low_skip: cover property (@(posedge REF_CLK_I) wr_any && wr_lowb_mode && !wr_low);
  c_can: cover property (@(posedge REF_CLK_I) start && CAN_SEL_I != 8'h00);
endmodule : ebsc_top

// ==== design/ebsc_map.svh ====
`ifndef EBSC_MAP_SVH
`define EBSC_MAP_SVH
// write strobe config field encodings
`define EBSC_WR_STROBE_FULL 1'h0
`define EBSC_WR_STROBE_LOWB 1'h1
// strobe, synchroniser and pin stage reset values
`define EBSC_STROBE_RST 1'h1
`define EBSC_SYNC_RST 1'h0
`define EBSC_PIN_RST 8'h00
// programmed wait state counter width and reset value
`define EBSC_WAIT_W 4
`define EBSC_WAIT_RST 4'h0
`define EBSC_SEG_RST 8'h00
`endif

// ==== design/ebsc_pkg.sv ====
package ebsc_pkg;
  typedef enum logic [1:0] {
    EBSC_IDLE = 2'h0,
    EBSC_WAIT = 2'h1,
    EBSC_RDY = 2'h3
  } ebsc_state_e;
  // one external access request from the core
  typedef struct packed {
    logic fetch;
    logic rd;
    logic wr;
    logic bus8;
    logic low_byte;
    logic [7:0] seg;
  } ebsc_req_s;
endpackage : ebsc_pkg

// ==== dv/ebsc_mem.sv ====
`timescale 1ns/1ps
module ebsc_mem (
  input wire logic clk_i, // system clock
  input wire logic strobe_n_i, // both strobes anded, low = access
  input wire logic [3:0] stall_i, // wait cycles to ask for
  output logic ready_o // high = wait
);
  logic [3:0] cnt_r = 4'h0;
  always @(posedge clk_i) begin
    if (strobe_n_i) cnt_r <= 4'h0;
    else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
  end
  assign ready_o = !strobe_n_i && (cnt_r < stall_i);
endmodule : ebsc_mem

// ==== dv/ext_bus_strobe_control_bench.sv ====
`timescale 1ns/1ps
module ext_bus_strobe_control_bench;
  logic clk = 0, rst = 1, valid = 0, done, wr_cfg = 0, ren = 0, ready, rd_n, wr_n;
  logic [3:0] stall = 4'h0, wcnt = 4'h1;
  logic [7:0] can_sel = 8'h00, can_tx = 8'h00, can_rx, seg_o, seg_oe;
  ebsc_pkg::ebsc_req_s req = '0;
  int n_errors = 0, tests_run = 0, c0, c1;
  logic rl, wl;
  always #5 clk = ~clk;
  ebsc_mem mem (.clk_i(clk), .strobe_n_i(rd_n & wr_n), .stall_i(stall), .ready_o(ready));
  ebsc_top dut (.REF_CLK_I(clk), .RST_I(rst), .REQ_VALID_I(valid), .REQ_I(req),
    .REQ_DONE_O(done), .WRITE_STROBE_CONFIG_FIELD_I(wr_cfg),
    .READY_EN_I(ren), .WAIT_CNT_I(wcnt),
    .READY_I(ready), .CAN_SEL_I(can_sel), .CAN_TX_I(can_tx), .CAN_RX_O(can_rx),
    .SEG_PORT_I(seg_o & seg_oe), .SEG_PORT_O(seg_o), .SEG_PORT_OE_O(seg_oe),
    .RD_N_O(rd_n), .WR_N_O(wr_n));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic access(input logic [4:0] k, input logic [7:0] s, output int cyc);
    valid = 1;
    req = {k, s};
    @(posedge clk);
    #1 valid = 0;
    cyc = 0;
    rl = 0;
    wl = 0;
    while (done !== 1'b1 && cyc < 60) begin
      if (rd_n === 1'b0) rl = 1;
      if (wr_n === 1'b0) wl = 1;
      @(posedge clk);
      #1 cyc++;
    end
    check("access done", done, 1);
    @(posedge clk);
    #1;
  endtask : access
  task automatic t_read;
    access(5'b10000, 8'h00, c0);
    check("fetch rd", rl, 1);
    check("fetch wr", wl, 0);
    access(5'b01000, 8'h00, c0);
    check("read rd", rl, 1);
  endtask : t_read
  task automatic t_write;
    for (int i = 0; i < 8; i++) begin
      wr_cfg = i[2];
      access({3'b001, i[1:0]}, 8'h00, c0);
      check("write rd", rl, 0);
      check("write wr", wl, !i[2] | i[1] | i[0]);
    end
  endtask : t_write
  task automatic t_ready;
    access(5'b01000, 8'h00, c0);
    check("wait count", c0, wcnt + 4'h1);
    stall = 4'h6;
    access(5'b01000, 8'h00, c1);
    check("no ready cycles", c1, c0);
    ren = 1;
    access(5'b01000, 8'h00, c1);
    check("ready stretch", c1 >= c0 + 3, 1);
    stall = 4'h0;
    access(5'b01000, 8'h00, c1);
    check("ready idle", c1, c0);
    wcnt = 4'h3;
    access(5'b01000, 8'h00, c1);
    check("wait count 3", c1, 8'h04);
  endtask : t_ready
  task automatic t_port;
    access(5'b01000, 8'h13, c0);
    check("seg order", seg_o, 8'h13);
    check("seg oe", seg_oe, 8'hFF);
    can_sel = 8'h0F;
    can_tx = 8'h05;
    access(5'b01000, 8'hA0, c0);
    repeat (3) @(posedge clk);
    #1 check("can tx", seg_o, 8'hA5);
    check("can rx", can_rx, 8'h05);
  endtask : t_port
  task automatic final_report;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    t_read();
    t_write();
    t_ready();
    t_port();
    final_report();
  end
endmodule : ext_bus_strobe_control_bench
